// *** litdec_pkg.sv ***
/*
 * Package for the literal and table instruction decoder: opcode fields,
 * encodings, reset values, phase and state enumerations and carrier structs.
 * Assumes a single instruction clock shared by fetch and execute.
 */
package litdec_pkg;

    localparam logic [7:0]  OP_ADD_IMM      = 8'h0F;
    localparam logic [7:0]  OP_AND_IMM      = 8'h0B;
    localparam logic [7:0]  OP_OR_IMM       = 8'h09;
    localparam logic [7:0]  OP_XOR_IMM      = 8'h0A;
    localparam logic [7:0]  OP_RSUB_IMM     = 8'h08;
    localparam logic [7:0]  OP_LOAD_IMM     = 8'h0E;
    localparam logic [7:0]  OP_MUL_IMM      = 8'h0D;
    localparam logic [7:0]  OP_RET_VAL      = 8'h0C;
    localparam logic [11:0] OP_BANK_HI      = 12'h010;
    localparam logic [7:0]  OP_PTR_FIRST    = 8'hEE;
    localparam logic [7:0]  OP_PTR_SECOND   = 8'hF0;
    localparam logic [3:0]  OP_SECOND_WORD  = 4'hF;
    localparam logic [11:0] OP_TABLE_HI     = 12'h000;
    localparam logic [1:0]  OP_TABLE_GROUP  = 2'b10;
    localparam logic [1:0]  OP_TABLE_WR     = 2'b11;
    localparam logic [1:0]  TBL_NONE        = 2'b00;
    localparam logic [1:0]  TBL_POST_INC    = 2'b01;
    localparam logic [1:0]  TBL_POST_DEC    = 2'b10;
    localparam logic [1:0]  TBL_PRE_INC     = 2'b11;

    localparam int          FLAG_C          = 0;
    localparam int          FLAG_DC         = 1;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_OV         = 3;
    localparam int          FLAG_N          = 4;

    localparam logic [7:0]  RST_WORK        = 8'h00;
    localparam logic [4:0]  RST_FLAGS       = 5'h00;
    localparam logic [3:0]  RST_BANK        = 4'h0;
    localparam logic [11:0] RST_PTR         = 12'h000;
    localparam logic [20:0] RST_TBLPTR      = 21'h00_0000;
    localparam logic [15:0] NOP_WORD        = 16'h0000;
    localparam int          PTR_COUNT       = 3;

    typedef enum logic [1:0] {
        LITDEC_Q_DECODE,
        LITDEC_Q_READ,
        LITDEC_Q_PROCESS,
        LITDEC_Q_WRITE
    } litdec_phase_t;

    typedef enum logic [1:0] {
        LITDEC_S_FIRST,
        LITDEC_S_PTR_TAIL,
        LITDEC_S_FLUSH,
        LITDEC_S_WRITE_BUSY
    } litdec_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic        valid;
    } litdec_fetch_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [20:0] addr;
        logic [7:0]  wdata;
    } litdec_table_t;

endpackage

// *** litdec_core.sv ***
/*
 * Decode and execute for the literal-operand and program memory table
 * instruction group, with flush, second-word and pointer load handling.
 * Assumes the fetch path presents one word per four-phase instruction
 * cycle, that the table port reports memory write completion, and that
 * port pins and timer prescaler assignment come from outside as pins.
 */
// Operation
// - Add literal to working register, all flags.
// - AND literal, update zero and negative only.
// - OR literal, update zero and negative only.
// - XOR literal, update zero and negative only.
// - Literal minus working register, all flags.
// - Load literal into working register, flags kept.
// - Multiply literal by working register, flags kept.
// - Load four-bit literal into bank select.
// - Two-word load of twelve-bit pointer value.
// - Load literal then return, two cycles.
// - Table read with four pointer variants.
// - Table write with same four variants.
// - Started memory write runs until finished.
// - Port self-modify reads pins, not latch.
// - Timer-zero write clears assigned prescaler.
// - Program counter change costs flushed cycle.
// - Lone second word executes as no-operation.
`timescale 1ns/1ps
module litdec_core
    import litdec_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire litdec_fetch_t fetch,
    input  wire logic [7:0]    table_rdata,
    input  wire logic          table_wr_done,
    input  wire logic [PORT_W-1:0] port_pins,
    input  wire logic          port_self_op,
    input  wire logic          timer_zero_write,
    input  wire logic          prescaler_on_timer,
    input  wire logic [7:0]    table_latch_in,
    output litdec_table_t      table_req,
    output logic [7:0]         working_register,
    output logic [4:0]         status_flags,
    output logic [3:0]         bank_select_register,
    output logic [PTR_COUNT*12-1:0] indirect_pointer,
    output logic [15:0]        product,
    output logic [20:0]        table_pointer,
    output logic [7:0]         table_latch,
    output logic               return_pulse,
    output logic               fetch_stall,
    output logic [PORT_W-1:0]  port_operand,
    output logic               prescaler_clear,
    output litdec_phase_t      phase
);

    logic rst_s1;
    logic rst_s2;
    logic [PORT_W-1:0] pins_s1;
    logic [PORT_W-1:0] pins_s2;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
        end else begin
            pins_s1 <= port_pins;
            pins_s2 <= pins_s1;
        end
    end

    litdec_state_t state;
    logic [15:0]   ir;
    logic [3:0]    ptr_hi;
    logic [1:0]    ptr_sel;
    logic          exec;

    // One instruction is taken per pass through the four phases.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            phase <= LITDEC_Q_DECODE;
        end else if (phase == LITDEC_Q_DECODE && !fetch.valid) begin
            phase <= LITDEC_Q_DECODE;
        end else begin
            phase <= litdec_phase_t'(phase + 2'd1);
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            ir <= NOP_WORD;
        end else if (phase == LITDEC_Q_DECODE && fetch.valid) begin
            ir <= fetch.word;
        end
    end

    wire [7:0] k    = ir[7:0];
    wire [7:0] hi   = ir[15:8];
    assign exec = (phase == LITDEC_Q_WRITE) && (state == LITDEC_S_FIRST);
    wire is_table = (ir[15:4] == OP_TABLE_HI) && (ir[3:2] >= OP_TABLE_GROUP);
    wire is_twr   = is_table && (ir[3:2] == OP_TABLE_WR);

    // Arithmetic for the add and reverse-subtract forms.
    logic [8:0] sum;
    logic [4:0] nib;
    logic       ov;
    always_comb begin
        sum = 9'd0;
        nib = 5'd0;
        ov  = 1'b0;
        if (hi == OP_ADD_IMM) begin
            sum = {1'b0, working_register} + {1'b0, k};
            nib = {1'b0, working_register[3:0]} + {1'b0, k[3:0]};
            ov  = (working_register[7] == k[7]) && (sum[7] != k[7]);
        end else begin
            sum = {1'b0, k} + {1'b0, ~working_register} + 9'd1;
            nib = {1'b0, k[3:0]} + {1'b0, ~working_register[3:0]} + 5'd1;
            ov  = (k[7] != working_register[7]) && (sum[7] != k[7]);
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            working_register <= RST_WORK;
            status_flags     <= RST_FLAGS;
        end else if (exec) begin
            case (hi)
                OP_ADD_IMM, OP_RSUB_IMM: begin
                    working_register     <= sum[7:0];
                    status_flags[FLAG_C] <= sum[8];
                    status_flags[FLAG_DC] <= nib[4];
                    status_flags[FLAG_Z] <= (sum[7:0] == 8'h00);
                    status_flags[FLAG_OV] <= ov;
                    status_flags[FLAG_N] <= sum[7];
                end
                OP_AND_IMM: begin
                    working_register     <= working_register & k;
                    status_flags[FLAG_Z] <= ((working_register & k) == 8'h00);
                    status_flags[FLAG_N] <= working_register[7] & k[7];
                end
                OP_OR_IMM: begin
                    working_register     <= working_register | k;
                    status_flags[FLAG_Z] <= ((working_register | k) == 8'h00);
                    status_flags[FLAG_N] <= working_register[7] | k[7];
                end
                OP_XOR_IMM: begin
                    working_register     <= working_register ^ k;
                    status_flags[FLAG_Z] <= ((working_register ^ k) == 8'h00);
                    status_flags[FLAG_N] <= working_register[7] ^ k[7];
                end
                OP_LOAD_IMM, OP_RET_VAL: begin
                    working_register <= k;
                end
                default: begin
                    if (is_table && !is_twr) begin
                        working_register <= working_register;
                    end
                end
            endcase
        end
    end

    // The product lands in its own register and flags are left alone.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            product <= 16'h0000;
        end else if (exec && hi == OP_MUL_IMM) begin
            product <= working_register * k;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            bank_select_register <= RST_BANK;
        end else if (exec && ir[15:4] == OP_BANK_HI) begin
            bank_select_register <= ir[3:0];
        end
    end

    // Pointer load: first word latches select and top nibble, second supplies the low byte.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            ptr_hi  <= 4'h0;
            ptr_sel <= 2'b00;
        end else if (exec && hi == OP_PTR_FIRST) begin
            ptr_hi  <= ir[3:0];
            ptr_sel <= ir[5:4];
        end
    end

    genvar g;
    generate
        for (g = 0; g < PTR_COUNT; g++) begin : g_ptr
            always_ff @(posedge clk or negedge rst_s2) begin
                if (!rst_s2) begin
                    indirect_pointer[g*12 +: 12] <= RST_PTR;
                end else if (phase == LITDEC_Q_WRITE && state == LITDEC_S_PTR_TAIL
                             && hi == OP_PTR_SECOND && ptr_sel == 2'(g)) begin
                    indirect_pointer[g*12 +: 12] <= {ptr_hi, k};
                end
            end
        end
    endgenerate

    // Sequencing of second cycles and a memory write in progress.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            state <= LITDEC_S_FIRST;
        end else if (state == LITDEC_S_WRITE_BUSY) begin
            // A completion report moves straight on to the flush cycle, however short the write.
            if (table_wr_done) begin
                state <= LITDEC_S_FLUSH;
            end
        end else if (phase == LITDEC_Q_WRITE) begin
            case (state)
                LITDEC_S_FIRST: begin
                    if (hi == OP_PTR_FIRST) begin
                        state <= LITDEC_S_PTR_TAIL;
                    end else if (is_twr) begin
                        state <= LITDEC_S_WRITE_BUSY;
                    end else if (hi == OP_RET_VAL || is_table) begin
                        state <= LITDEC_S_FLUSH;
                    end
                end
                LITDEC_S_PTR_TAIL: state <= LITDEC_S_FIRST;
                LITDEC_S_FLUSH:    state <= LITDEC_S_FIRST;
                default:           state <= LITDEC_S_FIRST;
            endcase
        end
    end

    // A lone second word falls through every decode above as a no-operation.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            fetch_stall <= 1'b0;
        end else begin
            fetch_stall <= (state == LITDEC_S_WRITE_BUSY) && !table_wr_done;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            return_pulse <= 1'b0;
        end else begin
            return_pulse <= exec && hi == OP_RET_VAL;
        end
    end

    // Table pointer update and table port request.
    logic [20:0] tp_use;
    always_comb begin
        tp_use = table_pointer;
        if (ir[1:0] == TBL_PRE_INC) begin
            tp_use = table_pointer + 21'd1;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            table_pointer <= RST_TBLPTR;
            table_req     <= '0;
        end else begin
            table_req.rd <= 1'b0;
            table_req.wr <= 1'b0;
            if (exec && is_table) begin
                table_req.rd    <= !is_twr;
                table_req.wr    <= is_twr;
                table_req.addr  <= tp_use;
                table_req.wdata <= table_latch_in;
                case (ir[1:0])
                    TBL_POST_INC: table_pointer <= table_pointer + 21'd1;
                    TBL_POST_DEC: table_pointer <= table_pointer - 21'd1;
                    TBL_PRE_INC:  table_pointer <= tp_use;
                    default:      table_pointer <= table_pointer;
                endcase
            end
        end
    end

    // By the flush write phase the opcode register holds the next word, so a
    // separate flag remembers that read data is due.
    logic rd_wait;
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            rd_wait     <= 1'b0;
            table_latch <= 8'h00;
        end else if (exec && is_table && !is_twr) begin
            rd_wait <= 1'b1;
        end else if (phase == LITDEC_Q_WRITE && rd_wait) begin
            rd_wait     <= 1'b0;
            table_latch <= table_rdata;
        end
    end

    // Self-modifying port operations see the synchronised pins.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            port_operand <= '0;
        end else if (port_self_op) begin
            port_operand <= pins_s2;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            prescaler_clear <= 1'b0;
        end else begin
            prescaler_clear <= timer_zero_write && prescaler_on_timer;
        end
    end

    property p_load_imm;
        @(posedge clk) disable iff (!rst_s2)
        exec && hi == OP_LOAD_IMM |=> working_register == $past(k) && $stable(status_flags);
    endproperty
    a_load_imm: assert property (p_load_imm) else $error("load immediate wrong");

    property p_and_flags;
        @(posedge clk) disable iff (!rst_s2)
        exec && hi == OP_AND_IMM |=> status_flags[FLAG_C] == $past(status_flags[FLAG_C]);
    endproperty
    a_and_flags: assert property (p_and_flags) else $error("and touched carry");

    property p_add_sum;
        @(posedge clk) disable iff (!rst_s2)
        exec && hi == OP_ADD_IMM |=> working_register == 8'($past(working_register) + $past(k));
    endproperty
    a_add_sum: assert property (p_add_sum) else $error("add result wrong");

    property p_bank;
        @(posedge clk) disable iff (!rst_s2)
        exec && ir[15:4] == OP_BANK_HI |=> bank_select_register == $past(ir[3:0]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");

    property p_ret;
        @(posedge clk) disable iff (!rst_s2)
        exec && hi == OP_RET_VAL |=> return_pulse ##1 state == LITDEC_S_FLUSH;
    endproperty
    a_ret: assert property (p_ret) else $error("return not two cycles");

    property p_busy;
        @(posedge clk) disable iff (!rst_s2)
        state == LITDEC_S_WRITE_BUSY && !table_wr_done |=> state == LITDEC_S_WRITE_BUSY;
    endproperty
    a_busy: assert property (p_busy) else $error("write abandoned");

    property p_pins;
        @(posedge clk) disable iff (!rst_s2)
        port_self_op |=> port_operand == $past(pins_s2);
    endproperty
    a_pins: assert property (p_pins) else $error("port operand not pins");

    property p_presc;
        @(posedge clk) disable iff (!rst_s2)
        timer_zero_write && prescaler_on_timer |=> prescaler_clear;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not cleared");

    property p_phase;
        @(posedge clk) disable iff (!rst_s2)
        phase == LITDEC_Q_READ |=> phase == LITDEC_Q_PROCESS ##1 phase == LITDEC_Q_WRITE;
    endproperty
    a_phase: assert property (p_phase) else $error("phase order broken");

endmodule

// *** litdec_mem_model.sv ***
/*
 * Partner model of the program memory table port: reads are answered with a
 * pattern of the address and writes report completion after wr_wait cycles.
 * Assumes one-cycle rd and wr pulses on the core clock.
 */
`timescale 1ns/1ps
module litdec_mem_model
    import litdec_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire litdec_table_t table_req,
    input  wire logic [3:0]    wr_wait,
    output logic [7:0]         table_rdata,
    output logic               table_wr_done,
    output logic [20:0]        last_addr,
    output logic [7:0]         last_wdata
);
    logic [3:0] age;
    logic [3:0] cnt;
    logic       busy;

    // Read data is held for eight cycles and then inverted, so a late sample shows up.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            table_rdata <= 8'h00;
            age         <= 4'h0;
        end else if (table_req.rd) begin
            table_rdata <= table_req.addr[7:0] ^ table_req.addr[15:8] ^ 8'h5A;
            age         <= 4'h8;
        end else if (age == 4'h1) begin
            table_rdata <= ~table_rdata;
            age         <= 4'h0;
        end else if (age != 4'h0) begin
            age <= age - 4'h1;
        end
    end

    // A started write always runs its whole count before completion is reported.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy          <= 1'b0;
            cnt           <= 4'h0;
            table_wr_done <= 1'b0;
            last_addr     <= 21'h00_0000;
            last_wdata    <= 8'h00;
        end else begin
            table_wr_done <= 1'b0;
            if (table_req.rd || table_req.wr) begin
                last_addr <= table_req.addr;
            end
            if (table_req.wr && !busy) begin
                busy       <= 1'b1;
                cnt        <= wr_wait;
                last_wdata <= table_req.wdata;
            end else if (busy && cnt <= 4'h1) begin
                busy          <= 1'b0;
                table_wr_done <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// *** literal_and_table_op_decoder_test.sv ***
/*
 * Self-checking testbench of the literal and table instruction decoder.
 * Assumes the memory partner model and one 125 MHz instruction clock.
 */
`timescale 1ns/1ps
module literal_and_table_op_decoder_test;
    import litdec_pkg::*;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    litdec_fetch_t fetch = '0;
    logic [7:0]    table_latch_in = 8'h00;
    logic [7:0]    port_pins = 8'h00;
    logic          port_self_op = 1'b0;
    logic          timer_zero_write = 1'b0;
    logic          prescaler_on_timer = 1'b0;
    logic [3:0]    wr_wait = 4'h1;
    litdec_table_t table_req;
    logic [7:0]    table_rdata, working_register, table_latch, last_wdata, port_operand;
    logic [4:0]    status_flags, ef;
    logic [3:0]    bank_select_register;
    logic [35:0]   indirect_pointer, ip;
    logic [15:0]   product;
    logic [20:0]   table_pointer, last_addr, tp, a;
    logic          table_wr_done, return_pulse, fetch_stall, prescaler_clear;
    litdec_phase_t phase;
    logic [7:0]    ew;
    logic [31:0]   seed = 32'h0000_0019;
    int            n_fail = 0, cmp_count = 0, cycles = 0, n_ret = 0, n_clr = 0, n_stall = 0;
    logic [7:0]    ops[7] = '{OP_ADD_IMM, OP_AND_IMM, OP_OR_IMM, OP_XOR_IMM, OP_RSUB_IMM,
                              OP_LOAD_IMM, OP_MUL_IMM};
    logic [23:0]   corner[5] = '{{OP_ADD_IMM, 8'h01, 8'hFF}, {OP_ADD_IMM, 8'h01, 8'h7F},
                                 {OP_RSUB_IMM, 8'h05, 8'h05}, {OP_RSUB_IMM, 8'h00, 8'h01},
                                 {OP_AND_IMM, 8'h00, 8'hFF}};

    litdec_core #(.PORT_W(8)) litdec_core_i (.clk(clk), .rst_b(rst_b), .fetch(fetch),
        .table_rdata(table_rdata), .table_wr_done(table_wr_done), .port_pins(port_pins),
        .port_self_op(port_self_op), .timer_zero_write(timer_zero_write),
        .prescaler_on_timer(prescaler_on_timer), .table_latch_in(table_latch_in),
        .table_req(table_req), .working_register(working_register),
        .status_flags(status_flags), .bank_select_register(bank_select_register),
        .indirect_pointer(indirect_pointer), .product(product),
        .table_pointer(table_pointer), .table_latch(table_latch),
        .return_pulse(return_pulse), .fetch_stall(fetch_stall),
        .port_operand(port_operand), .prescaler_clear(prescaler_clear), .phase(phase));
    litdec_mem_model litdec_mem_model_i (.clk(clk), .rst_b(rst_b), .table_req(table_req),
        .wr_wait(wr_wait), .table_rdata(table_rdata), .table_wr_done(table_wr_done),
        .last_addr(last_addr), .last_wdata(last_wdata));

    always #4 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (return_pulse === 1'b1) n_ret++;
        if (prescaler_clear === 1'b1) n_clr++;
        if (fetch_stall === 1'b1) n_stall++;
        if (cycles == 30000) begin
            n_fail++;
            conclude();
        end
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Returns the expected flags and working register after one literal operation.
    function automatic logic [12:0] alu(input logic [7:0] op, k, w, input logic [4:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        r = w;
        case (op)
            OP_ADD_IMM, OP_RSUB_IMM: begin
                s = (op == OP_ADD_IMM) ? {1'b0, k} + {1'b0, w} : {1'b0, k} + {1'b0, ~w} + 9'h001;
                h = (op == OP_ADD_IMM) ? {1'b0, k[3:0]} + {1'b0, w[3:0]}
                                       : {1'b0, k[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                r = s[7:0];
                f[FLAG_C] = s[8];
                f[FLAG_DC] = h[4];
                f[FLAG_OV] = (k[7] == (op == OP_ADD_IMM ? w[7] : ~w[7])) && (r[7] != k[7]);
            end
            OP_AND_IMM: r = k & w;
            OP_OR_IMM: r = k | w;
            OP_XOR_IMM: r = k ^ w;
            OP_LOAD_IMM: r = k;
            default: r = w;
        endcase
        if (op != OP_LOAD_IMM && op != OP_MUL_IMM) begin
            f[FLAG_Z] = (r == 8'h00);
            f[FLAG_N] = r[7];
        end
        return {f, r};
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Presents a word and returns just after the edge that takes it.
    task automatic issue(input logic [15:0] w);
        logic dec;
        fetch.word = w;
        for (int i = 0; i < 64; i++) begin
            dec = (phase == LITDEC_Q_DECODE) && (fetch_stall === 1'b0);
            @(posedge clk);
            #1;
            if (dec) break;
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] r;
        logic [23:0] c;
        logic [11:0] v;
        int          n0;
        repeat (8) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({working_register, status_flags, bank_select_register, table_pointer},
              {RST_WORK, RST_FLAGS, RST_BANK, RST_TBLPTR});
        check(indirect_pointer, {PTR_COUNT{RST_PTR}});
        ew = RST_WORK;
        ef = RST_FLAGS;
        tp = RST_TBLPTR;
        fetch.valid = 1'b1;
        for (int i = 0; i < 47; i++) begin
            r = rnd();
            c = (i < 5) ? corner[i] : {ops[int'(r[18:16]) % 7], r[7:0], r[15:8]};
            issue({OP_LOAD_IMM, c[7:0]});
            issue({c[23:16], c[15:8]});
            issue(NOP_WORD);
            {ef, ew} = alu(c[23:16], c[15:8], c[7:0], ef);
            check(working_register, ew);
            check(status_flags, ef);
            if (c[23:16] == OP_MUL_IMM) check(product, c[15:8] * c[7:0]);
        end
        for (int k = 0; k < 16; k++) begin
            issue({OP_BANK_HI, 4'(k)});
            issue(NOP_WORD);
            check({bank_select_register, status_flags}, {4'(k), ef});
        end
        for (int g = 0; g < PTR_COUNT; g++) begin
            v = 12'(rnd());
            issue({OP_PTR_FIRST, 2'b00, 2'(g), v[11:8]});
            issue({OP_PTR_SECOND, v[7:0]});
            issue(NOP_WORD);
            check(indirect_pointer[g*12+:12], v);
            check(working_register, ew);
        end
        ip = indirect_pointer;
        issue({OP_PTR_SECOND, 8'h3C});
        issue(16'hF5A5);
        issue(NOP_WORD);
        check({working_register, status_flags}, {ew, ef});
        check(indirect_pointer, ip);
        n0 = n_ret;
        r = rnd();
        issue({OP_RET_VAL, r[7:0]});
        issue({OP_ADD_IMM, 8'h01});
        issue(NOP_WORD);
        ew = r[7:0];
        check({working_register, status_flags}, {ew, ef});
        check(n_ret - n0, 1);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            a = (i[1:0] == TBL_PRE_INC) ? tp + 21'h1 : tp;
            table_latch_in = r[7:0];
            wr_wait = i[0] ? 4'h9 : 4'h1;
            n0 = n_stall;
            issue({OP_TABLE_HI, i[2] ? OP_TABLE_WR : OP_TABLE_GROUP, i[1:0]});
            issue({OP_ADD_IMM, 8'h01});
            issue(NOP_WORD);
            check(working_register, ew);
            if (i[1:0] == TBL_POST_DEC) tp = tp - 21'h1;
            else if (i[1:0] != TBL_NONE) tp = tp + 21'h1;
            check({last_addr, table_pointer}, {a, tp});
            if (!i[2]) check(table_latch, a[7:0] ^ a[15:8] ^ 8'h5A);
            if (i[2]) check({last_wdata, status_flags}, {r[7:0], ef});
            if (i[2]) check(n_stall - n0 >= int'(wr_wait), 1);
        end
        issue(NOP_WORD);
        check(phase, LITDEC_Q_READ);
        fetch.valid = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(phase, LITDEC_Q_DECODE);
        fetch.valid = 1'b1;
        r = rnd();
        port_pins = r[7:0];
        port_self_op = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        check(port_operand, r[7:0]);
        port_self_op = 1'b0;
        for (int i = 0; i < 2; i++) begin
            n0 = n_clr;
            prescaler_on_timer = !i[0];
            timer_zero_write = 1'b1;
            @(posedge clk);
            #1;
            timer_zero_write = 1'b0;
            repeat (4) @(posedge clk);
            #1;
            check(n_clr - n0, !i[0]);
        end
        conclude();
    end
endmodule
